// file: logic/stmr_pkg.sv
// Shared constants, types and helpers for the sleep timer
`default_nettype none
package stmr_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int STMR_CNT_W  = 24;
	localparam int STMR_BYTE_W = 8;

	// ----------------------------------------------------------------
	// Register offsets (SFR addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] STMR_OFF_LOW  = 8'h95;
	localparam logic [7:0] STMR_OFF_MID  = 8'h96;
	localparam logic [7:0] STMR_OFF_HIGH = 8'h97;

	// ----------------------------------------------------------------
	// Field positions inside the 24-bit count / compare word
	// ----------------------------------------------------------------
	localparam int STMR_LOW_LSB  = 0;
	localparam int STMR_MID_LSB  = 8;
	localparam int STMR_HIGH_LSB = 16;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [23:0] STMR_CNT_RST  = 24'h000000;
	localparam logic [23:0] STMR_CMP_RST  = 24'hFFFFFF;
	localparam logic [7:0]  STMR_BYTE_RST = 8'h00;

	// ----------------------------------------------------------------
	// Power modes as driven by the power manager
	// ----------------------------------------------------------------
	localparam logic [1:0] STMR_PM_ACTIVE = 2'h0;
	localparam logic [1:0] STMR_PM_LIGHT  = 2'h1;
	localparam logic [1:0] STMR_PM_DEEP   = 2'h2;

	// ----------------------------------------------------------------
	// Timing: low-frequency clock against the 125 MHz system clock
	// ----------------------------------------------------------------
	localparam real STMR_LF_FREQ_KHZ  = 32.768;
	localparam real STMR_SYS_FREQ_MHZ = 125.0;
	// Nominal spacing of two ticks in system cycles, rounded down
	localparam int  STMR_LF_PERIOD_CYC = int'($floor(STMR_SYS_FREQ_MHZ * 1000.0 / STMR_LF_FREQ_KHZ));

	// ----------------------------------------------------------------
	// SFR access carrier
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
	} stmr_sfr_req_type;

	// Address decode used by reads and writes alike
	function automatic logic stmr_hit(input logic [7:0] addr, input logic [7:0] off);
		return addr == off;
	endfunction

endpackage
`default_nettype wire

// file: logic/stmr_sync.sv
// Two-flop synchroniser of the low-frequency clock pin with rising-edge tick
`timescale 1ns/10ps
`default_nettype none
module stmr_sync
	import stmr_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic lf_clk_pin,
	output var  logic tick_q
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// ----------------------------------------------------------------
	// Synchroniser: meta_q feeds sync_q only
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= lf_clk_pin;
			sync_q <= meta_q;
		end
	end

	// Rising edge of the settled level gives one tick per LF period
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			prev_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			prev_q <= sync_q;
			tick_q <= sync_q & ~prev_q;
		end
	end

endmodule // stmr_sync
`default_nettype wire

// file: logic/stmr_flag.sv
// Sticky event flag whose set beats a simultaneous clear
`timescale 1ns/10ps
`default_nettype none
module stmr_flag
	import stmr_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic set,
	input  wire logic clr,
	output var  logic flag_q
);

	logic flag_d;

	// ----------------------------------------------------------------
	// Set wins so an event landing on the clear cycle is kept
	// ----------------------------------------------------------------
	always_comb begin
		flag_d = flag_q;
		if (clr) begin
			flag_d = 1'b0;
		end
		if (set) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

endmodule // stmr_flag
`default_nettype wire

// file: logic/stmr_top.sv
// Sleep timer: 24-bit LF counter, compare, flag, DMA trigger and wake-up
//
// Contract
// - A 24-bit counter steps up once per period of the 32.768 kHz clock.
// - Counting starts at reset release and never stops or pauses.
// - A compare event occurs when the count equals the 24-bit compare value.
// - A compare event raises the sleep compare flag, interrupt number 5.
// - The flag sits in the irq flag register and the enable bit gates the request.
// - The counter runs in light and deep sleep and a match wakes to active mode.
// - After reset the compare value is all ones.
// - Each compare event pulses DMA trigger source 9.
// - The high byte reads count bits 23..16 and writes compare bits 23..16.
// - The middle byte reads count bits 15..8 and writes compare bits 15..8.
// - Reading the low byte snapshots the upper bytes; read the low byte first.
// - High and middle writes wait and load with the low-byte write; write low last.
// - The count is offered as the timebase that carries the MAC timer across sleep.
// - The low byte reads count bits 7..0 and writes compare bits 7..0.
`timescale 1ns/10ps
`default_nettype none
module stmr_top
	import stmr_pkg::*;
#(
	parameter int CNT_W = STMR_CNT_W
)
(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             lf_clk_pin,
	input  wire stmr_sfr_req_type sfr_req,
	output var  logic [7:0]       sfr_rdata_q,
	output var  logic             sfr_rvalid_q,
	input  wire logic [1:0]       power_mode,
	input  wire logic             sleep_irq_enable,
	input  wire logic             sleep_flag_clear,
	output var  logic             sleep_compare_flag,
	output var  logic             sleep_irq_req_q,
	output var  logic             sleep_dma_trig_q,
	output var  logic             wake_req_q,
	output var  logic [CNT_W-1:0] mac_timebase_q
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic             tick;
	logic             tick_d1_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cmp_q;
	logic [7:0]       pend_high_q;
	logic [7:0]       pend_mid_q;
	logic [15:0]      snap_q;
	logic             match;
	logic             hit_low;
	logic             hit_mid;
	logic             hit_high;
	logic             in_sleep;

	// ----------------------------------------------------------------
	// LF tick
	// ----------------------------------------------------------------
	stmr_sync stmr_sync_inst (
		.sys_clk    (sys_clk),
		.rst        (rst),
		.lf_clk_pin (lf_clk_pin),
		.tick_q     (tick)
	);

	// ----------------------------------------------------------------
	// Free-running counter
	// ----------------------------------------------------------------
	// No enable input: the count cannot be stopped by software or mode
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= CNT_W'(STMR_CNT_RST);
		end else if (tick) begin
			cnt_q <= cnt_q + CNT_W'(1);
		end
	end

	// Delayed tick marks the first cycle the new count is visible
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tick_d1_q <= 1'b0;
		end else begin
			tick_d1_q <= tick;
		end
	end

	// Count exported to the MAC timer for sleep bridging
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			mac_timebase_q <= CNT_W'(STMR_CNT_RST);
		end else begin
			mac_timebase_q <= cnt_q;
		end
	end

	// ----------------------------------------------------------------
	// SFR decode
	// ----------------------------------------------------------------
	assign hit_low  = stmr_hit(sfr_req.addr, STMR_OFF_LOW);
	assign hit_mid  = stmr_hit(sfr_req.addr, STMR_OFF_MID);
	assign hit_high = stmr_hit(sfr_req.addr, STMR_OFF_HIGH);

	// ----------------------------------------------------------------
	// Compare value with staged upper bytes
	// ----------------------------------------------------------------
	// Staging keeps a half-written compare from firing a spurious match
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pend_high_q <= STMR_BYTE_RST;
			pend_mid_q  <= STMR_BYTE_RST;
		end else if (sfr_req.wr) begin
			if (hit_high) begin
				pend_high_q <= sfr_req.wdata;
			end
			if (hit_mid) begin
				pend_mid_q <= sfr_req.wdata;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmp_q <= CNT_W'(STMR_CMP_RST);
		end else if (sfr_req.wr && hit_low) begin
			cmp_q <= CNT_W'({pend_high_q, pend_mid_q, sfr_req.wdata});
		end
	end

	// ----------------------------------------------------------------
	// Read path with low-byte snapshot
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			snap_q <= {STMR_BYTE_RST, STMR_BYTE_RST};
		end else if (sfr_req.rd && hit_low) begin
			snap_q <= cnt_q[STMR_HIGH_LSB+7:STMR_MID_LSB];
		end
	end

	// Unmapped reads return zero; data is valid one cycle after rd
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sfr_rdata_q  <= STMR_BYTE_RST;
			sfr_rvalid_q <= 1'b0;
		end else begin
			sfr_rvalid_q <= sfr_req.rd;
			if (!sfr_req.rd) begin
				sfr_rdata_q <= sfr_rdata_q;
			end else if (hit_low) begin
				sfr_rdata_q <= cnt_q[STMR_LOW_LSB+7:STMR_LOW_LSB];
			end else if (hit_mid) begin
				sfr_rdata_q <= snap_q[7:0];
			end else if (hit_high) begin
				sfr_rdata_q <= snap_q[15:8];
			end else begin
				sfr_rdata_q <= STMR_BYTE_RST;
			end
		end
	end

	// ----------------------------------------------------------------
	// Compare event
	// ----------------------------------------------------------------
	// Checked only on a fresh count so one value gives one event
	assign match    = tick_d1_q && (cnt_q == cmp_q);
	assign in_sleep = (power_mode == STMR_PM_LIGHT) || (power_mode == STMR_PM_DEEP);

	stmr_flag stmr_flag_inst (
		.sys_clk (sys_clk),
		.rst     (rst),
		.set     (match),
		.clr     (sleep_flag_clear),
		.flag_q  (sleep_compare_flag)
	);

	// Event outputs
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sleep_dma_trig_q <= 1'b0;
			wake_req_q       <= 1'b0;
		end else begin
			sleep_dma_trig_q <= match;
			wake_req_q       <= match && in_sleep;
		end
	end

	// Request follows flag one cycle later; enable gates it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sleep_irq_req_q <= 1'b0;
		end else begin
			sleep_irq_req_q <= sleep_compare_flag && sleep_irq_enable;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	logic first_q;
	logic [12:0] gap_q;

	// Marks the first cycle after reset release
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			first_q <= 1'b1;
		end else begin
			first_q <= 1'b0;
		end
	end

	// Cycles since last tick, saturating
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gap_q <= 13'h0000;
		end else if (tick) begin
			gap_q <= 13'h0000;
		end else if (gap_q != 13'h1FFF) begin
			gap_q <= gap_q + 13'h0001;
		end
	end

	AST_CNT_STEP: assert property (tick |=> cnt_q == $past(cnt_q) + CNT_W'(1))
		else $error("counter did not step on tick");
	AST_CNT_HOLD: assert property (!tick |=> $stable(cnt_q))
		else $error("counter moved without tick");
	// Wrap needs the full 24-bit span of ticks, so only long runs or formal reach it
	AST_CNT_WRAP: assert property (tick && (&cnt_q) |=> cnt_q == '0)
		else $error("counter did not wrap to zero");
	AST_CMP_RESET: assert property (first_q |-> cmp_q == CNT_W'(STMR_CMP_RST))
		else $error("compare not all ones after reset");
	AST_MATCH_EVT: assert property (tick ##1 (cnt_q == cmp_q) |=> sleep_dma_trig_q && sleep_compare_flag)
		else $error("match missed");
	AST_DMA_CAUSE: assert property (sleep_dma_trig_q |-> $past(cnt_q == cmp_q) && $past(tick, 2))
		else $error("dma trigger without match");
	AST_FLAG_KEEP: assert property (sleep_compare_flag && !sleep_flag_clear |=> sleep_compare_flag)
		else $error("flag dropped without clear");
	AST_IRQ_GATE: assert property (sleep_irq_req_q |-> $past(sleep_irq_enable) && $past(sleep_compare_flag))
		else $error("irq without enabled flag");
	AST_WAKE: assert property (match && in_sleep |=> wake_req_q ##1 !wake_req_q)
		else $error("wake not a single pulse on sleep match");
	AST_HIGH_RD: assert property (sfr_req.rd && hit_high |=> sfr_rdata_q == $past(snap_q[15:8]))
		else $error("high byte read wrong");
	AST_MID_RD: assert property (sfr_req.rd && hit_mid |=> sfr_rdata_q == $past(snap_q[7:0]))
		else $error("middle byte read wrong");
	AST_SNAP: assert property (sfr_req.rd && hit_low |=> snap_q == $past(cnt_q[23:8])
		&& sfr_rdata_q == $past(cnt_q[7:0]))
		else $error("low read did not snapshot");
	AST_CMP_LOAD: assert property (sfr_req.wr && hit_low |=> cmp_q == {$past(pend_high_q),
		$past(pend_mid_q), $past(sfr_req.wdata)})
		else $error("compare load wrong");
	AST_CMP_STABLE: assert property (!(sfr_req.wr && hit_low) |=> $stable(cmp_q))
		else $error("compare changed without low write");
	AST_MAC_TB: assert property (tick_d1_q |=> mac_timebase_q == $past(cnt_q))
		else $error("timebase lags count");

	// ----------------------------------------------------------------
	// Start-up, event and read-path checks
	// ----------------------------------------------------------------
	// Release starts from zero with no stale event left from before reset
	AST_CNT_START: assert property (first_q |-> cnt_q == CNT_W'(STMR_CNT_RST))
		else $error("count not zero after reset");
	AST_NO_EARLY_EVT: assert property (first_q |-> !sleep_compare_flag && !sleep_dma_trig_q)
		else $error("event present right after reset");
	AST_TICK_SINGLE: assert property (tick |=> !tick)
		else $error("one pin edge gave two ticks");
	AST_DMA_PULSE: assert property (sleep_dma_trig_q |=> !sleep_dma_trig_q)
		else $error("dma trigger longer than one cycle");
	AST_FLAG_SET: assert property (match |=> sleep_compare_flag)
		else $error("match did not set the flag");
	AST_WAKE_CAUSE: assert property (wake_req_q |-> $past(match) && $past(in_sleep))
		else $error("wake without a match in sleep");
	AST_IRQ_SET: assert property (sleep_compare_flag && sleep_irq_enable |=> sleep_irq_req_q)
		else $error("enabled flag gave no request");

	// Staged bytes and snapshot move only on their own access
	AST_PEND_HIGH: assert property (!(sfr_req.wr && hit_high) |=> $stable(pend_high_q))
		else $error("staged high byte changed without a write");
	AST_PEND_MID: assert property (!(sfr_req.wr && hit_mid) |=> $stable(pend_mid_q))
		else $error("staged middle byte changed without a write");
	AST_SNAP_HOLD: assert property (!(sfr_req.rd && hit_low) |=> $stable(snap_q))
		else $error("snapshot moved without a low read");
	AST_RVALID: assert property (sfr_req.rd |=> sfr_rvalid_q)
		else $error("read not answered after one cycle");
	// Read data stands until the next read so a slow master still sees it
	AST_RDATA_HOLD: assert property (!sfr_req.rd |=> $stable(sfr_rdata_q))
		else $error("read data changed without a read");

	// Main scenarios the bench should reach
	COV_MATCH: cover property (match);
	COV_WAKE: cover property (wake_req_q);
	COV_FULL_WRITE: cover property (sfr_req.wr && hit_high ##[1:8] sfr_req.wr && hit_mid
		##[1:8] sfr_req.wr && hit_low);
	COV_SET_CLR: cover property (match && sleep_flag_clear);
	COV_TICK_GAP: cover property (tick && gap_q >= 13'(STMR_LF_PERIOD_CYC - 2));

endmodule // stmr_top
`default_nettype wire

// file: sim/stmr_top_test.sv
// Self-checking bench for the sleep timer through its SFR port and event outputs
`timescale 1ns/10ps
`default_nettype none
module stmr_top_test
	import stmr_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals, clock and design
	// ----------------------------------------------------------------
	logic             sys_clk;
	logic             rst;
	logic             lf_clk_pin;
	stmr_sfr_req_type sfr_req;
	logic [7:0]       sfr_rdata_q;
	logic             sfr_rvalid_q;
	logic [1:0]       power_mode;
	logic             sleep_irq_enable;
	logic             sleep_flag_clear;
	logic             sleep_compare_flag;
	logic             sleep_irq_req_q;
	logic             sleep_dma_trig_q;
	logic             wake_req_q;
	logic [23:0]      mac_timebase_q;
	int               error_cnt;
	int               n_checks;
	int               dma_cnt;
	int               wake_cnt;
	int               base_dma;
	int               base_wake;
	logic [7:0]       rd_val;
	logic [1:0]       pm_tab [3];

	// 125 MHz system clock
	always #4 sys_clk = ~sys_clk;

	stmr_top #(.CNT_W(STMR_CNT_W)) stmr_top_inst (
		.sys_clk            (sys_clk),
		.rst                (rst),
		.lf_clk_pin         (lf_clk_pin),
		.sfr_req            (sfr_req),
		.sfr_rdata_q        (sfr_rdata_q),
		.sfr_rvalid_q       (sfr_rvalid_q),
		.power_mode         (power_mode),
		.sleep_irq_enable   (sleep_irq_enable),
		.sleep_flag_clear   (sleep_flag_clear),
		.sleep_compare_flag (sleep_compare_flag),
		.sleep_irq_req_q    (sleep_irq_req_q),
		.sleep_dma_trig_q   (sleep_dma_trig_q),
		.wake_req_q         (wake_req_q),
		.mac_timebase_q     (mac_timebase_q)
	);

	// Count event pulses; a pulse longer than one cycle shows up as extra counts
	always @(posedge sys_clk) begin
		if (sleep_dma_trig_q === 1'b1)
			dma_cnt++;
		if (wake_req_q === 1'b1)
			wake_cnt++;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Read: rd held for the taking edge, data picked up with rvalid (bounded wait)
	task automatic sfr_rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge sys_clk);
		sfr_req <= '{addr: addr, rd: 1'b1, wr: 1'b0, wdata: 8'h00};
		@(posedge sys_clk);
		sfr_req.rd <= 1'b0;
		repeat (4) begin
			#1;
			if (sfr_rvalid_q === 1'b1)
				break;
			@(posedge sys_clk);
		end
		chk("read valid", 24'(sfr_rvalid_q), 24'h000001);
		data = sfr_rdata_q;
	endtask

	task automatic sfr_wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge sys_clk);
		sfr_req <= '{addr: addr, rd: 1'b0, wr: 1'b1, wdata: data};
		@(posedge sys_clk);
		sfr_req.wr <= 1'b0;
	endtask

	// Slow LF clock: far shorter than the real period, but each level spans several cycles
	task automatic lf_tick(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			lf_clk_pin <= 1'b1;
			repeat (4) @(posedge sys_clk);
			lf_clk_pin <= 1'b0;
			repeat (6) @(posedge sys_clk);
		end
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		rst = 1'b1;
		lf_clk_pin = 1'b0;
		sfr_req = '0;
		power_mode = STMR_PM_ACTIVE;
		sleep_irq_enable = 1'b0;
		sleep_flag_clear = 1'b0;
		error_cnt = 0;
		n_checks = 0;
		dma_cnt = 0;
		wake_cnt = 0;
		pm_tab = '{STMR_PM_ACTIVE, STMR_PM_LIGHT, STMR_PM_DEEP};
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		// Fresh count reads zero in every byte; unmapped place reads zero
		sfr_rd(STMR_OFF_LOW, rd_val);
		chk("count low", 24'(rd_val), 24'h000000);
		sfr_rd(STMR_OFF_MID, rd_val);
		chk("count mid", 24'(rd_val), 24'h000000);
		sfr_rd(STMR_OFF_HIGH, rd_val);
		chk("count high", 24'(rd_val), 24'h000000);
		sfr_rd(8'h94, rd_val);
		chk("unmapped", 24'(rd_val), 24'h000000);
		// Count up to the low-byte edge; all-ones compare must stay silent
		lf_tick(255);
		#1;
		chk("timebase", mac_timebase_q, 24'h0000FF);
		chk("early events", 24'(dma_cnt), 24'h000000);
		sfr_rd(STMR_OFF_LOW, rd_val);
		chk("count low", 24'(rd_val), 24'h0000FF);
		// Carry into the middle byte after the snapshot was taken
		lf_tick(1);
		sfr_rd(STMR_OFF_MID, rd_val);
		chk("snapshot mid", 24'(rd_val), 24'h000000);
		sfr_rd(STMR_OFF_HIGH, rd_val);
		chk("snapshot high", 24'(rd_val), 24'h000000);
		sfr_rd(STMR_OFF_LOW, rd_val);
		chk("count low", 24'(rd_val), 24'h000000);
		sfr_rd(STMR_OFF_MID, rd_val);
		chk("count mid", 24'(rd_val), 24'h000001);
		// One match per power mode; a trailing staged middle byte must not move the compare
		for (int m = 0; m < 3; m++) begin
			@(posedge sys_clk);
			power_mode <= pm_tab[m];
			sleep_irq_enable <= m[0];
			sfr_wr(STMR_OFF_HIGH, 8'h00);
			sfr_wr(STMR_OFF_MID, 8'h01);
			sfr_wr(STMR_OFF_LOW, 8'(3 * m + 3));
			sfr_wr(STMR_OFF_MID, 8'h05);
			base_dma = dma_cnt;
			base_wake = wake_cnt;
			lf_tick(3);
			repeat (2) @(posedge sys_clk);
			#1;
			chk("dma pulses", 24'(dma_cnt - base_dma), 24'h000001);
			chk("compare flag", 24'(sleep_compare_flag), 24'h000001);
			chk("wake pulses", 24'(wake_cnt - base_wake), (m > 0) ? 24'h000001 : 24'h000000);
			chk("irq request", 24'(sleep_irq_req_q), 24'(m[0]));
			@(posedge sys_clk);
			sleep_flag_clear <= 1'b1;
			@(posedge sys_clk);
			sleep_flag_clear <= 1'b0;
			repeat (2) @(posedge sys_clk);
			#1;
			chk("cleared flag", 24'(sleep_compare_flag), 24'h000000);
			chk("cleared irq", 24'(sleep_irq_req_q), 24'h000000);
		end
		sfr_rd(STMR_OFF_LOW, rd_val);
		chk("count low", 24'(rd_val), 24'h000009);
		sfr_rd(STMR_OFF_MID, rd_val);
		chk("count mid", 24'(rd_val), 24'h000001);
		stop_test();
	end

	// Watchdog: the sequence needs about 3000 cycles
	initial begin
		repeat (12000) @(posedge sys_clk);
		error_cnt++;
		stop_test();
	end

endmodule // stmr_top_test
`default_nettype wire
